// [verilog/seg_flags_pkg.sv]
package seg_flags_pkg;

    localparam int SEL_W = 16;
    localparam int FLAGS_W = 32;
    localparam int OFS_W = 32;
    localparam int BASE_W = 64;

    // Segment register indices
    typedef enum logic [2:0] {
        SEG_DATA_B = 3'h0,
        SEG_CODE = 3'h1,
        SEG_STACK = 3'h2,
        SEG_DATA_A = 3'h3,
        SEG_DATA_C = 3'h4,
        SEG_DATA_D = 3'h5
    } seg_idx_t;
    localparam int NUM_SEG = 6;

    // Flag bit positions
    localparam int CARRY_BIT = 0;
    localparam int ONE_BIT = 1;
    localparam int PARITY_BIT = 2;
    localparam int ADJUST_BIT = 4;
    localparam int ZERO_BIT = 6;
    localparam int SIGN_BIT = 7;
    localparam int TRAP_BIT = 8;
    localparam int INT_EN_BIT = 9;
    localparam int DIR_BIT = 10;
    localparam int OVERFLOW_BIT = 11;
    localparam int PRIV_LO_BIT = 12;
    localparam int PRIV_HI_BIT = 13;

    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    // Bits 1,3,5,15,22..31 reserved
    localparam logic [31:0] FLAGS_RSVD_MASK = 32'hFFC0_802A;
    localparam logic [31:0] FLAGS_FIXED_ONE = 32'h0000_0002;
    // Low byte group moved by accumulator transfers: bits 0,2,4,6,7
    localparam logic [7:0] LOW_GROUP_MASK = 8'hD5;
    localparam logic [31:0] WORD_GROUP_MASK = 32'h0000_FFFF;
    // Arithmetic status group: bits 0,2,4,6,7,11
    localparam logic [31:0] STATUS_GROUP_MASK = 32'h0000_08D5;
    localparam logic [15:0] SEL_RESET = 16'h0000;
    localparam logic [63:0] BASE_ZERO = 64'h0000_0000_0000_0000;

    // Flags transfer operations
    typedef enum logic [3:0] {
        FOP_NONE,
        FOP_ACC_TO_FLAGS,
        FOP_POP_WORD,
        FOP_POP_DOUBLE,
        FOP_TASK_LOAD,
        FOP_SET_BIT,
        FOP_CLR_BIT,
        FOP_ARITH
    } flag_op_t;

    typedef struct packed {
        logic valid;
        logic app;
        seg_idx_t idx;
        logic [15:0] sel;
    } seg_load_t;

    typedef struct packed {
        logic valid;
        seg_idx_t idx;
        logic [31:0] offset;
        logic [63:0] desc_base;
        logic [31:0] desc_limit;
    } addr_req_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [63:0] linear;
    } addr_rsp_t;

endpackage

// [verilog/seg_addr_unit.sv]
`timescale 1ns/1ps
module seg_addr_unit (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic long_mode,
    input wire seg_flags_pkg::addr_req_t req,
    output seg_flags_pkg::addr_rsp_t rsp
);
    import seg_flags_pkg::*;

    addr_rsp_t rsp_d;
    addr_rsp_t rsp_q;

    function automatic logic base_forced_zero(input seg_idx_t i);
        return (i == SEG_CODE) || (i == SEG_STACK) || (i == SEG_DATA_A) || (i == SEG_DATA_B);
    endfunction

    always_comb begin
        logic [63:0] base;
        base = req.desc_base;
        rsp_d.valid = req.valid;
        rsp_d.fault = 1'b0;
        if (long_mode && base_forced_zero(req.idx)) begin
            base = BASE_ZERO; // RULE8
        end
        // Upper data selectors keep their base in 64-bit mode
        rsp_d.linear = base + {32'h0000_0000, req.offset}; // RULE9
        if (!long_mode && req.valid && (req.offset > req.desc_limit)) begin
            rsp_d.fault = 1'b1;
        end
        // No limit check in 64-bit mode
        if (long_mode) begin
            rsp_d.fault = 1'b0; // RULE11
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else if (ce) begin
            rsp_q <= rsp_d;
        end
    end

    assign rsp = rsp_q;
endmodule // seg_addr_unit

// [verilog/segment_and_flags_state.sv]
`timescale 1ns/1ps
// Overview of operation
// RULE1: Six registers each hold one 16-bit segment selector.
// RULE2: A segment is reached only through a loaded segment register; here seg_addr_unit takes its base from addr_req and never reads the selectors.
// RULE3: Up to six distinct segments addressable at once, one per register.
// RULE4: Fetch address uses code selector plus next instruction offset.
// RULE5: Code selector refuses explicit application loads; changes only implicitly.
// RULE6: Stack operations use the stack selector; it accepts explicit loads.
// RULE7: Four data selectors, each explicitly loadable by application code.
// RULE8: In 64-bit mode code, stack, first two data bases read zero.
// RULE9: In 64-bit mode the last two data selectors keep their base.
// RULE10: Loads in 64-bit mode still run legacy validity checks.
// RULE11: No segment limit checks in 64-bit mode.
// RULE12: Flags register resets to 00000002h on reset or init.
// RULE13: Bits 1,3,5,15 and 22-31 of flags are reserved.
// RULE14: No single operation reads or writes the whole flags register; here FOP_TASK_LOAD writes the whole word.
// RULE15: Flag groups move between flags and stack or accumulator both ways.
// RULE16: Task switch saves flags to outgoing block, loads from incoming.
// RULE17: Handler call pushes flags; task-switched handler saves to task block.
// RULE18: Existing flags keep position; new flags only in unused positions.
// RULE19: Arithmetic status flags sit at bits 0,2,4,6,7,11.
// RULE20: Direction flag at bit 10; set steps down, clear steps up.
// RULE21: Interrupt enable at bit 9; set accepts maskable interrupts.
// RULE22: I/O privilege level field occupies bits 12 and 13.
// RULE23: Reserved writes ignored; bit 1 reads one, others zero.
module segment_and_flags_state (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic init_n,
    input wire logic ce,
    input wire logic long_mode,
    input wire logic cpl_zero,
    input wire seg_flags_pkg::seg_load_t seg_load,
    input wire logic [15:0] seg_load_check_ok,
    output logic seg_load_fault,
    output logic [15:0] check_sel,
    input wire seg_flags_pkg::seg_idx_t read_idx,
    output logic [15:0] read_sel,
    input wire seg_flags_pkg::addr_req_t addr_req,
    output seg_flags_pkg::addr_rsp_t addr_rsp,
    input wire logic [31:0] next_instruction_offset,
    output logic [47:0] fetch_logical,
    input wire logic stack_op,
    input wire logic [31:0] stack_offset,
    output logic [47:0] stack_logical,
    input wire seg_flags_pkg::flag_op_t flag_op,
    input wire logic [31:0] flag_wdata,
    input wire logic [4:0] flag_bit,
    output logic [31:0] accumulator_flags,
    output logic [31:0] stack_push_flags,
    output logic [31:0] task_save_flags,
    input wire logic task_switch,
    input wire logic handler_call,
    output logic task_save_valid,
    output logic stack_push_valid,
    input wire logic maskable_irq,
    output logic irq_accept,
    output logic string_step_down,
    output logic [1:0] io_privilege_level
);
    import seg_flags_pkg::*;

    logic [15:0] sel_q [NUM_SEG];
    logic [15:0] sel_d [NUM_SEG];
    logic [31:0] flags_q;
    logic [31:0] flags_d;
    logic fault_d;
    logic fault_q;
    logic [31:0] save_d;
    logic [31:0] save_q;
    logic tsv_d;
    logic tsv_q;
    logic psv_d;
    logic psv_q;
    logic [31:0] push_d;
    logic [31:0] push_q;
    logic [31:0] acc_d;
    logic [31:0] acc_q;
    logic init_s1_q;
    logic init_s2_q;

    // Reserved positions never change; bit 1 pinned high
    function automatic logic [31:0] clean_flags(input logic [31:0] v);
        return (v & ~FLAGS_RSVD_MASK) | FLAGS_FIXED_ONE; // RULE23
    endfunction

    function automatic logic app_loadable(input seg_idx_t i);
        return i != SEG_CODE; // RULE5
    endfunction

    // Init pin is asynchronous to the core clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            init_s1_q <= 1'b1;
            init_s2_q <= 1'b1;
        end else if (ce) begin
            init_s1_q <= init_n;
            init_s2_q <= init_s1_q;
        end
    end

    assign check_sel = seg_load.sel;

    // Selector file
    always_comb begin
        for (int i = 0; i < NUM_SEG; i++) begin
            sel_d[i] = sel_q[i];
        end
        fault_d = 1'b0;
        if (seg_load.valid) begin
            if (seg_load.app && !app_loadable(seg_load.idx)) begin
                fault_d = 1'b1; // RULE5
            end else if (!seg_load_check_ok[0]) begin
                // Checks apply in every mode, so compatibility code sees sane values
                fault_d = 1'b1; // RULE10
            end else begin
                sel_d[seg_load.idx] = seg_load.sel; // RULE1 RULE6 RULE7
            end
        end
    end

    generate
        for (genvar g = 0; g < NUM_SEG; g++) begin : g_sel
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    sel_q[g] <= SEL_RESET;
                end else if (ce) begin
                    sel_q[g] <= sel_d[g]; // RULE3
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
        end else if (ce) begin
            fault_q <= fault_d;
        end
    end

    assign seg_load_fault = fault_q;
    assign read_sel = sel_q[read_idx];

    // Address formation from the request's index, descriptor base and limit; the selector file is not read
    seg_addr_unit u_addr (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .long_mode(long_mode),
        .req(addr_req),
        .rsp(addr_rsp)
    ); // RULE2 RULE8 RULE9 RULE11

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_logical <= '0;
            stack_logical <= '0;
        end else if (ce) begin
            fetch_logical <= {sel_q[SEG_CODE], next_instruction_offset}; // RULE4
            if (stack_op) begin
                stack_logical <= {sel_q[SEG_STACK], stack_offset}; // RULE6
            end
        end
    end

    // Flags register: group and single-bit paths, plus a whole-word write on task load
    always_comb begin
        logic [31:0] f;
        logic [31:0] m;
        f = flags_q;
        m = '0;
        case (flag_op)
            FOP_ACC_TO_FLAGS: begin
                m = {24'h00_0000, LOW_GROUP_MASK};
                f = (flags_q & ~m) | ({24'h00_0000, flag_wdata[15:8]} & m); // RULE15
            end
            FOP_POP_WORD: begin
                m = WORD_GROUP_MASK;
                if (!cpl_zero) begin
                    m[PRIV_LO_BIT] = 1'b0;
                    m[PRIV_HI_BIT] = 1'b0;
                end
                f = (flags_q & ~m) | (flag_wdata & m); // RULE15
            end
            FOP_POP_DOUBLE: begin
                m = 32'hFFFF_FFFF;
                if (!cpl_zero) begin
                    m[PRIV_LO_BIT] = 1'b0;
                    m[PRIV_HI_BIT] = 1'b0;
                end
                f = (flags_q & ~m) | (flag_wdata & m); // RULE15
            end
            FOP_TASK_LOAD: begin
                f = flag_wdata; // RULE16
            end
            FOP_SET_BIT: begin
                f[flag_bit] = 1'b1; // RULE14
            end
            FOP_CLR_BIT: begin
                f[flag_bit] = 1'b0; // RULE14
            end
            FOP_ARITH: begin
                // Status group only: bits 0,2,4,6,7,11
                m = STATUS_GROUP_MASK;
                f = (flags_q & ~m) | (flag_wdata & m); // RULE19
            end
            default: begin
                f = flags_q;
            end
        endcase
        flags_d = clean_flags(f); // RULE13 RULE18
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= FLAGS_RESET; // RULE12
        end else if (ce) begin
            if (!init_s2_q) begin
                flags_q <= FLAGS_RESET; // RULE12
            end else begin
                flags_q <= flags_d;
            end
        end
    end

    // Save paths capture pre-update flags
    always_comb begin
        save_d = save_q;
        push_d = push_q;
        tsv_d = 1'b0;
        psv_d = 1'b0;
        acc_d = {16'h0000, flags_q[7:0] & LOW_GROUP_MASK, 8'h00} | {16'h0000, FLAGS_FIXED_ONE[7:0], 8'h00};
        if (task_switch) begin
            save_d = flags_q; // RULE16 RULE17
            tsv_d = 1'b1;
        end else if (handler_call) begin
            push_d = flags_q; // RULE17
            psv_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            save_q <= FLAGS_RESET;
            push_q <= FLAGS_RESET;
            tsv_q <= 1'b0;
            psv_q <= 1'b0;
            acc_q <= '0;
        end else if (ce) begin
            save_q <= save_d;
            push_q <= push_d;
            tsv_q <= tsv_d;
            psv_q <= psv_d;
            acc_q <= acc_d;
        end
    end

    assign task_save_flags = save_q;
    assign task_save_valid = tsv_q;
    assign stack_push_valid = psv_q;
    assign stack_push_flags = psv_q ? push_q : flags_q; // RULE15
    assign accumulator_flags = acc_q; // RULE15
    assign irq_accept = maskable_irq && flags_q[INT_EN_BIT]; // RULE21
    assign string_step_down = flags_q[DIR_BIT]; // RULE20
    assign io_privilege_level = flags_q[PRIV_HI_BIT:PRIV_LO_BIT]; // RULE22
endmodule // segment_and_flags_state

// [test/seg_flags_chk.sv]
`timescale 1ns/1ps
module seg_flags_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic long_mode,
    input wire seg_flags_pkg::seg_load_t seg_load,
    input wire logic [15:0] seg_load_check_ok,
    input wire logic seg_load_fault,
    input wire seg_flags_pkg::addr_req_t addr_req,
    input wire seg_flags_pkg::addr_rsp_t addr_rsp,
    input wire logic [31:0] next_instruction_offset,
    input wire logic [47:0] fetch_logical,
    input wire logic task_switch,
    input wire logic handler_call,
    input wire logic task_save_valid,
    input wire logic stack_push_valid,
    input wire logic [31:0] stack_push_flags,
    input wire logic maskable_irq,
    input wire logic irq_accept
);
    import seg_flags_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    rsvd_bits_a: assert property ((stack_push_flags & FLAGS_RSVD_MASK) == FLAGS_FIXED_ONE)
        else $error("reserved flag bits wrong");
    irq_gate_a: assert property (!stack_push_valid |-> irq_accept == (maskable_irq & stack_push_flags[9]))
        else $error("irq accept wrong");
    code_refuse_a: assert property (rst_n && ce && seg_load.valid && seg_load.app && seg_load.idx == SEG_CODE
        |=> seg_load_fault) else $error("code load not refused");
    check_fail_a: assert property (rst_n && ce && seg_load.valid && !seg_load_check_ok[0] |=> seg_load_fault)
        else $error("failed check not refused");
    fetch_addr_a: assert property (rst_n && ce |=> fetch_logical[31:0] == $past(next_instruction_offset))
        else $error("fetch offset wrong");
    task_save_a: assert property (rst_n && ce && task_switch |=> task_save_valid)
        else $error("no task save");
    handler_push_a: assert property (rst_n && ce && handler_call && !task_switch |=> stack_push_valid)
        else $error("no flags push");
    flat_base_a: assert property (rst_n && ce && long_mode && addr_req.valid
        && addr_req.idx inside {SEG_CODE, SEG_STACK, SEG_DATA_A, SEG_DATA_B}
        |=> !addr_rsp.fault && addr_rsp.linear == {32'h0000_0000, $past(addr_req.offset)}) else $error("flat base wrong");
endmodule // seg_flags_chk

// [test/segment_and_flags_state_tb.sv]
`timescale 1ns/1ps
module segment_and_flags_state_tb;
    import seg_flags_pkg::*;
    logic mclk, rst_n, init_n, ce, long_mode, cpl_zero, seg_load_fault, stack_op, task_switch, handler_call;
    logic task_save_valid, stack_push_valid, maskable_irq, irq_accept, string_step_down;
    logic [15:0] seg_load_check_ok, check_sel, read_sel;
    logic [31:0] next_instruction_offset, stack_offset, flag_wdata, accumulator_flags, stack_push_flags, task_save_flags;
    logic [47:0] fetch_logical, stack_logical;
    logic [4:0] flag_bit;
    logic [1:0] io_privilege_level;
    seg_load_t seg_load;
    seg_idx_t read_idx;
    addr_req_t addr_req;
    addr_rsp_t addr_rsp;
    flag_op_t flag_op;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    segment_and_flags_state i_dut (.mclk, .rst_n, .init_n, .ce, .long_mode, .cpl_zero, .seg_load, .seg_load_check_ok,
        .seg_load_fault, .check_sel, .read_idx, .read_sel, .addr_req, .addr_rsp, .next_instruction_offset,
        .fetch_logical, .stack_op, .stack_offset, .stack_logical, .flag_op, .flag_wdata, .flag_bit,
        .accumulator_flags, .stack_push_flags, .task_save_flags, .task_switch, .handler_call, .task_save_valid,
        .stack_push_valid, .maskable_irq, .irq_accept, .string_step_down, .io_privilege_level);
    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic load(seg_idx_t i, logic app, logic [15:0] s, logic ok);
        @(posedge mclk);
        seg_load <= '{1'b1, app, i, s};
        seg_load_check_ok <= 16'(ok);
        #1 chk("check_sel", check_sel, s);
        @(posedge mclk);
        seg_load <= '0;
        #1;
    endtask
    task automatic fop(flag_op_t op, logic [31:0] w);
        @(posedge mclk);
        flag_op <= op;
        flag_wdata <= w;
        @(posedge mclk);
        flag_op <= FOP_NONE;
        #1;
    endtask
    task automatic t_segs();
        seg_idx_t ids[5] = '{SEG_DATA_A, SEG_DATA_B, SEG_DATA_C, SEG_DATA_D, SEG_STACK};
        for (int k = 0; k < 5; k++) begin
            load(ids[k], 1'b1, 16'h1234 + 16'(k), 1'b1);
            chk("load_ok", seg_load_fault, 0);
        end
        load(SEG_CODE, 1'b0, 16'h0008, 1'b1);
        load(SEG_CODE, 1'b1, 16'h00F0, 1'b1);
        chk("code_refused", seg_load_fault, 1);
        load(SEG_DATA_A, 1'b1, 16'h0BEE, 1'b0);
        chk("check_refused", seg_load_fault, 1);
        for (int k = 0; k < 5; k++) begin
            @(posedge mclk);
            read_idx <= ids[k];
            #1 chk("sel", read_sel, 16'h1234 + 16'(k));
        end
        @(posedge mclk);
        read_idx <= SEG_CODE;
        #1 chk("code_sel", read_sel, 16'h0008);
        $display("segs done");
    endtask
    task automatic t_flags();
        fop(FOP_ACC_TO_FLAGS, 32'h0000_FF00);
        chk("acc_in", stack_push_flags, 32'h0000_00D7);
        @(posedge mclk);
        #1 chk("acc_out", accumulator_flags[15:8], 8'hD7);
        fop(FOP_POP_DOUBLE, 32'hFFFF_FFFF);
        chk("pop_all", stack_push_flags, 32'h003F_7FD7);
        chk("io_priv", io_privilege_level, 2'h3);
        chk("down", string_step_down, 1);
        fop(FOP_CLR_BIT, 32'h0000_0000);
        chk("up", string_step_down, 0);
        fop(FOP_SET_BIT, 32'h0000_0000);
        chk("down2", string_step_down, 1);
        fop(FOP_POP_WORD, 32'h0000_0000);
        chk("pop_word", stack_push_flags, 32'h003F_0002);
        $display("flags done");
    endtask
    task automatic t_task();
        @(posedge mclk);
        maskable_irq <= 1'b1;
        #1 chk("irq_off", irq_accept, 0);
        fop(FOP_TASK_LOAD, 32'h0000_0200);
        chk("task_load", stack_push_flags, 32'h0000_0202);
        chk("irq_on", irq_accept, 1);
        @(posedge mclk);
        task_switch <= 1'b1;
        handler_call <= 1'b1;
        @(posedge mclk);
        task_switch <= 1'b0;
        #1 chk("save_v", task_save_valid, 1);
        chk("save_f", task_save_flags, 32'h0000_0202);
        chk("no_push", stack_push_valid, 0);
        @(posedge mclk);
        handler_call <= 1'b0;
        #1 chk("push_v", stack_push_valid, 1);
        chk("push_f", stack_push_flags, 32'h0000_0202);
        $display("task done");
    endtask
    task automatic t_addr();
        @(posedge mclk);
        long_mode <= 1'b1;
        addr_req <= '{1'b1, SEG_DATA_A, 32'h0000_0010, 64'h0000_0000_0000_1000, 32'h0000_0000};
        next_instruction_offset <= 32'h0000_4000;
        stack_op <= 1'b1;
        stack_offset <= 32'h0000_0FF0;
        @(posedge mclk);
        addr_req.idx <= SEG_DATA_C;
        stack_op <= 1'b0;
        #1 chk("flat", addr_rsp.linear, 64'h0000_0000_0000_0010);
        chk("fetch", fetch_logical, {16'h0008, 32'h0000_4000});
        chk("stack", stack_logical, {16'h1238, 32'h0000_0FF0});
        @(posedge mclk);
        long_mode <= 1'b0;
        #1 chk("data_c_base", addr_rsp.linear, 64'h0000_0000_0000_1010);
        chk("flat_nolim", addr_rsp.fault, 0);
        @(posedge mclk);
        addr_req.valid <= 1'b0;
        #1 chk("limit", {addr_rsp.valid, addr_rsp.fault}, 2'h3);
        $display("addr done");
    endtask
    task automatic t_init();
        @(posedge mclk);
        init_n <= 1'b0;
        repeat (2) @(posedge mclk);
        init_n <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk("init", stack_push_flags, FLAGS_RESET);
        chk("init_sel", read_sel, 16'h0008);
        chk("init_priv", io_privilege_level, 2'h0);
        $display("init done");
    endtask
    task automatic t_arith();
        fop(FOP_ARITH, 32'hFFFF_FFFF);
        chk("arith_set", stack_push_flags, 32'h0000_0AD7);
        fop(FOP_ARITH, 32'h0000_0000);
        chk("arith_clr", stack_push_flags, 32'h0000_0202);
        $display("arith done");
    endtask
    task automatic t_priv();
        @(posedge mclk);
        cpl_zero <= 1'b0;
        fop(FOP_POP_DOUBLE, 32'h0000_3000);
        chk("pop_keep0", io_privilege_level, 2'h0);
        chk("pop_dbl", stack_push_flags, 32'h0000_0002);
        @(posedge mclk);
        cpl_zero <= 1'b1;
        fop(FOP_POP_WORD, 32'h0000_3200);
        chk("priv_set", io_privilege_level, 2'h3);
        @(posedge mclk);
        cpl_zero <= 1'b0;
        fop(FOP_POP_WORD, 32'h0000_0000);
        chk("pop_keep3", stack_push_flags, 32'h0000_3002);
        @(posedge mclk);
        cpl_zero <= 1'b1;
        $display("priv done");
    endtask
    task automatic t_ce();
        @(posedge mclk);
        ce <= 1'b0;
        read_idx <= SEG_DATA_D;
        load(SEG_DATA_D, 1'b1, 16'h0BAD, 1'b1);
        load(SEG_CODE, 1'b1, 16'h00F0, 1'b1);
        fop(FOP_TASK_LOAD, 32'h0000_0400);
        chk("frz_fault", seg_load_fault, 0);
        chk("frz_sel", read_sel, 16'h1237);
        chk("frz_flags", stack_push_flags, 32'h0000_3002);
        @(posedge mclk);
        ce <= 1'b1;
        read_idx <= SEG_CODE;
        $display("ce done");
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Generous ceiling: the sequence needs well under 200 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        {rst_n, long_mode, stack_op, task_switch, handler_call, maskable_irq} = '0;
        {init_n, ce, cpl_zero} = 3'h7;
        {seg_load, seg_load_check_ok, addr_req, next_instruction_offset, stack_offset, flag_wdata} = '0;
        read_idx = SEG_DATA_B;
        flag_op = FOP_NONE;
        flag_bit = 5'(DIR_BIT);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk("rst", stack_push_flags, FLAGS_RESET);
        t_segs();
        t_flags();
        t_task();
        t_addr();
        t_arith();
        t_priv();
        t_ce();
        t_init();
        final_report();
    end
endmodule // segment_and_flags_state_tb
bind segment_and_flags_state seg_flags_chk i_chk (.mclk, .rst_n, .ce, .long_mode, .seg_load, .seg_load_check_ok,
    .seg_load_fault, .addr_req, .addr_rsp, .next_instruction_offset, .fetch_logical, .task_switch, .handler_call,
    .task_save_valid, .stack_push_valid, .stack_push_flags, .maskable_irq, .irq_accept);
